// ===== testbench.sv
// testbench: register-level tests of the interrupt enable and line status block
// assumes the core model stands in for fifos and shift registers
`timescale 1ns/1ps
module testbench;
	import uart_irq_pkg::*;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	bus_req_t bus = '0;
	logic push = 1'b0;
	logic ovr = 1'b0;
	logic [10:0] ch = '0;
	logic [7:0] msr = '0;
	rx_stat_t rx;
	tx_stat_t tx;
	cfg_t cfg;
	logic [7:0] rxd, rd_data, interrupt_mask, txd;
	logic pop, tpush, rrst, polled, irq;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;

	uart_irq_ctrl i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus),
		.rx_data_i(rxd), .rx_i(rx), .tx_i(tx), .msr_i(msr), .rd_data_o(rd_data),
		.cfg_o(cfg), .ier_o(interrupt_mask), .rx_pop_o(pop), .tx_push_o(tpush), .tx_data_o(txd),
		.rx_fifo_reset_o(rrst), .tx_fifo_reset_o(), .msr_read_o(),
		.polled_mode_o(polled), .int_o(irq));
	uart_core_model i_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .push_i(push),
		.char_i(ch), .ovr_i(ovr), .rx_pop_i(pop), .tx_push_i(tpush),
		.rx_fifo_reset_i(rrst), .rx_o(rx), .tx_o(tx), .rx_data_o(rxd));

	initial forever #10 clk_sys_i = ~clk_sys_i;

	task automatic give_verdict();
		if (n_fail == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		bus <= '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge clk_sys_i);
		bus <= '0;
		#1;
	endtask : acc

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(rd_data, exp);
	endtask : rd

	// the interrupt output lags its cause by a register, so allow a few cycles
	task automatic irq_chk(input logic exp);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({7'h00, irq}, {7'h00, exp});
	endtask : irq_chk

	task automatic put(input logic [2:0] e, input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			push <= 1'b1;
			ch <= {e, 8'hA5};
		end
		@(posedge clk_sys_i);
		push <= 1'b0;
	endtask : put

	initial begin
		repeat (20) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rd(A_MASK, 8'h00);
		rd(A_LSR, 8'h60);
		rd(A_ISR, 8'h01);
		wr(A_HOLD, 8'h5A);
		wr(A_LCR, 8'h80);
		wr(A_ISR, 8'h3C);
		rd(A_ISR, 8'h00);
		wr(A_HOLD, 8'h12);
		wr(A_MASK, 8'h34);
		rd(A_HOLD, 8'h12);
		rd(A_MASK, 8'h34);
		wr(A_LCR, 8'h03);
		rd(A_MASK, 8'h00);
		wr(A_MASK, 8'hFF);
		rd(A_MASK, 8'h0F);
		rd(A_ISR, 8'h02);
		wr(A_MASK, 8'h00);
		irq_chk(1'b0);
		wr(A_MASK, 8'h02);
		irq_chk(1'b1);
		rd(A_ISR, 8'h02);
		irq_chk(1'b0);
		wr(A_MASK, 8'h01);
		put(3'h0, 1);
		irq_chk(1'b1);
		rd(A_ISR, 8'h04);
		rd(A_HOLD, 8'hA5);
		irq_chk(1'b0);
		wr(A_ISR, 8'h03);
		wr(A_MASK, 8'h00);
		rd(A_ISR, 8'hC1);
		chk({7'h00, polled}, 8'h01);
		wr(A_MASK, 8'h01);
		put(3'h0, 7);
		irq_chk(1'b0);
		put(3'h0, 1);
		irq_chk(1'b1);
		rd(A_ISR, 8'hC4);
		rd(A_HOLD, 8'hA5);
		irq_chk(1'b0);
		rd(A_LSR, 8'h61);
		wr(A_ISR, 8'h07);
		wr(A_MASK, 8'h05);
		put(3'h0, 1);
		put(3'h1, 1);
		rd(A_LSR, 8'hE1);
		irq_chk(1'b1);
		rd(A_ISR, 8'hC6);
		rd(A_HOLD, 8'hA5);
		rd(A_LSR, 8'hE5);
		rd(A_HOLD, 8'hA5);
		rd(A_LSR, 8'h60);
		irq_chk(1'b0);
		// ten-bit frames: the time-out falls 52 bit ticks after the last push
		put(3'h0, 1);
		repeat (40) @(posedge clk_sys_i);
		irq_chk(1'b0);
		repeat (12) @(posedge clk_sys_i);
		irq_chk(1'b1);
		rd(A_ISR, 8'hCC);
		rd(A_HOLD, 8'hA5);
		irq_chk(1'b0);
		@(posedge clk_sys_i);
		ovr <= 1'b1;
		@(posedge clk_sys_i);
		ovr <= 1'b0;
		irq_chk(1'b1);
		rd(A_LSR, 8'h62);
		rd(A_LSR, 8'h60);
		wr(A_MASK, 8'h0A);
		@(posedge clk_sys_i);
		msr <= 8'h01;
		irq_chk(1'b1);
		rd(A_ISR, 8'hC2);
		rd(A_ISR, 8'hC0);
		rd(A_MSR, 8'h01);
		@(posedge clk_sys_i);
		msr <= 8'h00;
		irq_chk(1'b0);
		wr(A_LCR, LCR_ENH_KEY);
		wr(A_ISR, 8'h10);
		rd(A_ISR, 8'h10);
		wr(A_LCR, 8'h83);
		wr(A_ISR, 8'h3C);
		rd(A_ISR, 8'h3C);
		wr(A_LCR, 8'h03);
		wr(A_MASK, 8'hF0);
		rd(A_MASK, 8'hF0);
		give_verdict();
	end
endmodule : testbench

// ===== uart_core_model.sv
// uart_core_model: behavioural channel core with receive fifo and draining transmit side
// assumes the bench commands pushes and overruns on the same clock
`timescale 1ns/1ps
module uart_core_model (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic push_i,
	input wire logic [10:0] char_i,
	input wire logic ovr_i,
	input wire logic rx_pop_i,
	input wire logic tx_push_i,
	input wire logic rx_fifo_reset_i,
	output uart_irq_pkg::rx_stat_t rx_o,
	output uart_irq_pkg::tx_stat_t tx_o,
	output logic [7:0] rx_data_o
);
	import uart_irq_pkg::*;
	logic [10:0] q[$];
	// char_i is {errors, data}; empty fifo inverts the shown byte on every clock
	always @(posedge clk_sys_i) begin
		if (srst_i || rx_fifo_reset_i) q.delete();
		else begin
			if (rx_pop_i && q.size() > 0) void'(q.pop_front());
			if (push_i) q.push_back(char_i);
		end
		rx_o.push <= push_i && !srst_i;
		rx_o.push_err <= char_i[10:8];
		rx_o.overrun <= ovr_i;
		// one bit time per clock keeps the receive time-out short enough to reach
		rx_o.bit_tick <= !srst_i;
		rx_o.level <= 7'(q.size());
		rx_o.head_err <= (q.size() > 0) ? q[0][10:8] : 3'h0;
		rx_data_o <= (q.size() > 0) ? q[0][7:0] : ~rx_data_o;
		tx_o.tsr_empty <= (tx_o.level == 7'h00);
		if (srst_i) tx_o.level <= 7'h00;
		else if (tx_push_i) tx_o.level <= tx_o.level + 7'h01;
		else if (tx_o.level != 7'h00) tx_o.level <= tx_o.level - 7'h01;
	end
endmodule : uart_core_model

// ===== uart_irq_ctrl.sv
// uart_irq_ctrl: register file, interrupt enables, line status and interrupt source logic
// assumes a synchronous host port (one-cycle rd/wr strobes on clk_sys_i) and fifo status
// from the channel core on the same clock.
`timescale 1ns/1ps
module uart_irq_ctrl (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire uart_irq_pkg::bus_req_t bus_i,
	input wire logic [7:0] rx_data_i,
	input wire uart_irq_pkg::rx_stat_t rx_i,
	input wire uart_irq_pkg::tx_stat_t tx_i,
	input wire logic [7:0] msr_i,
	output logic [7:0] rd_data_o,
	output uart_irq_pkg::cfg_t cfg_o,
	output logic [7:0] ier_o,
	output logic rx_pop_o,
	output logic tx_push_o,
	output logic [7:0] tx_data_o,
	output logic rx_fifo_reset_o,
	output logic tx_fifo_reset_o,
	output logic msr_read_o,
	output logic polled_mode_o,
	output logic int_o
);
	import uart_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state
	cfg_t cfg_r;
	logic [7:0] ier_r;
	logic [7:0] rd_data_r;
	logic rx_pop_r;
	logic tx_push_r;
	logic [7:0] tx_data_r;
	logic rx_rst_r;
	logic tx_rst_r;
	logic msr_rd_r;
	logic polled_r;
	logic int_r;
	logic ovr_r;
	logic [6:0] errcnt_r;
	logic tx_pend_r;
	logic tx_cond_q_r;
	logic [7:0] tout_cnt_r;
	logic tout_r;

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	wire dl_sel = cfg_r.line_control_reg[LCR_DL_EN];
	wire enh_sel = (cfg_r.line_control_reg == LCR_ENH_KEY);
	wire enh_en = cfg_r.enhanced_feature_control[EFR_ENH];
	wire [2:0] a = bus_i.addr;
	wire [7:0] wd = bus_i.wdata;
	wire wr = bus_i.wr;
	wire rd = bus_i.rd;

	wire wr_hold = wr && (a == A_HOLD) && !dl_sel;
	wire wr_dll = wr && (a == A_HOLD) && dl_sel;
	wire wr_dlm = wr && (a == A_MASK) && dl_sel;
	wire wr_ier = wr && (a == A_MASK) && !dl_sel;
	wire wr_fcr = wr && (a == A_ISR) && !dl_sel;
	wire wr_efr = wr && (a == A_ISR) && enh_sel;
	wire wr_dld = wr && (a == A_ISR) && dl_sel && !enh_sel && enh_en;
	wire wr_lcr = wr && (a == A_LCR);
	wire wr_mcr = wr && (a == A_MCR) && !enh_sel;
	wire wr_spr = wr && (a == A_SPR) && !enh_sel;
	wire wr_res1 = wr && (a == A_RESUME1) && enh_sel;
	wire wr_res2 = wr && (a == A_RESUME2) && enh_sel;
	wire wr_pau1 = wr && (a == A_PAUSE1) && enh_sel;
	wire wr_pau2 = wr && (a == A_PAUSE2) && enh_sel;

	wire rx_nonempty = (rx_i.level != 7'h00);
	wire rd_hold = rd && (a == A_HOLD) && !dl_sel;
	wire pop = rd_hold && rx_nonempty;
	wire rd_isr = rd && (a == A_ISR) && !dl_sel;
	wire rd_lsr = rd && (a == A_LSR) && !enh_sel;
	wire rd_msr = rd && (a == A_MSR) && !enh_sel;

	////////////////////////////////////////////////////////////////////////////////
	// write data with enhanced-only bits held while enhanced mode is off
	wire [7:0] ier_nxt = enh_en ? wd : {ier_r[7:4], wd[3:0]};
	wire [7:0] mcr_nxt = enh_en ? wd : {cfg_r.modem_control_reg[7:5], wd[4:0]};
	wire [1:0] tx_trig_sel_nxt = enh_en ? wd[5:4] : cfg_r.tx_trig_sel;
	wire fcr_take = wr_fcr && wd[FCR_FIFO_EN];
	wire ier_tx_rise = wr_ier && ier_nxt[IER_TX] && !ier_r[IER_TX];

	////////////////////////////////////////////////////////////////////////////////
	// line status
	wire fifo_en = cfg_r.fifo_en;
	wire [2:0] head_err = rx_nonempty ? rx_i.head_err : 3'h0;
	wire gerr = (errcnt_r != 7'h00);
	wire thr_empty = (tx_i.level == 7'h00);
	wire tx_all_empty = thr_empty && tx_i.tsr_empty;
	wire [7:0] lsr_w = {gerr, tx_all_empty, thr_empty, head_err, ovr_r, rx_nonempty};

	wire push_bad = rx_i.push && (rx_i.push_err != 3'h0);
	wire pop_bad = pop && (rx_i.head_err != 3'h0);
	wire [6:0] errcnt_nxt = errcnt_r + {6'h00, push_bad} - {6'h00, pop_bad};

	////////////////////////////////////////////////////////////////////////////////
	// trigger levels
	logic [6:0] rx_trig;
	logic [6:0] tx_trig;
	always_comb begin
		case (cfg_r.rx_trig_sel)
			2'h0: rx_trig = RX_TRIG_0;
			2'h1: rx_trig = RX_TRIG_1;
			2'h2: rx_trig = RX_TRIG_2;
			default: rx_trig = RX_TRIG_3;
		endcase
		case (cfg_r.tx_trig_sel)
			2'h0: tx_trig = TX_TRIG_0;
			2'h1: tx_trig = TX_TRIG_1;
			2'h2: tx_trig = TX_TRIG_2;
			default: tx_trig = TX_TRIG_3;
		endcase
	end

	wire [6:0] tx_space = FIFO_DEPTH - tx_i.level;
	wire tx_cond = fifo_en ? ((tx_space > tx_trig) || thr_empty) : thr_empty;
	wire tx_set = (tx_cond && !tx_cond_q_r) || (ier_tx_rise && tx_cond);

	////////////////////////////////////////////////////////////////////////////////
	// receive time-out: 4 characters plus 12 bits, counted in bit ticks
	wire [3:0] char_bits = 4'h7 + {2'h0, cfg_r.line_control_reg[1:0]} + {3'h0, cfg_r.line_control_reg[LCR_PAR_EN]}
		+ {3'h0, cfg_r.line_control_reg[LCR_STOP]};
	wire [7:0] tout_limit = 8'(TOUT_CHARS * {4'h0, char_bits}) + TOUT_EXTRA_BITS;
	wire tout_restart = rx_i.push || pop || !rx_nonempty;
	wire tout_set = fifo_en && !tout_restart && rx_i.bit_tick
		&& (tout_cnt_r == tout_limit - 8'h01);

	////////////////////////////////////////////////////////////////////////////////
	// enabled sources and priority
	wire ls_irq = ier_r[IER_LS] && (lsr_w[1] || (lsr_w[4:2] != 3'h0) || lsr_w[7]);
	wire tout_irq = ier_r[IER_RX] && tout_r && fifo_en;
	wire rx_irq = ier_r[IER_RX] && (fifo_en ? (rx_i.level >= rx_trig) : rx_nonempty);
	wire tx_irq = ier_r[IER_TX] && tx_pend_r;
	wire ms_irq = ier_r[IER_MS] && (msr_i[3:0] != 4'h0);
	wire any_irq = ls_irq || tout_irq || rx_irq || tx_irq || ms_irq;

	logic [5:0] isr_code;
	always_comb begin
		if (ls_irq) begin
			isr_code = ISR_LS;
		end else if (tout_irq) begin
			isr_code = ISR_TOUT;
		end else if (rx_irq) begin
			isr_code = ISR_RECEIVE_READY_EVENT;
		end else if (tx_irq) begin
			isr_code = ISR_TRANSMIT_READY_EVENT;
		end else if (ms_irq) begin
			isr_code = ISR_MS;
		end else begin
			isr_code = ISR_NONE;
		end
	end
	wire [7:0] isr_w = {fifo_en, fifo_en, isr_code};
	wire tx_clr = (rd_isr && (isr_code == ISR_TRANSMIT_READY_EVENT)) || wr_hold;

	////////////////////////////////////////////////////////////////////////////////
	// read mux
	logic [7:0] rd_mux;
	always_comb begin
		case (a)
			A_HOLD: rd_mux = dl_sel ? cfg_r.dll : rx_data_i;
			A_MASK: rd_mux = dl_sel ? cfg_r.baud_divisor_high : ier_r;
			A_ISR: rd_mux = enh_sel ? cfg_r.enhanced_feature_control : (dl_sel ? cfg_r.fraction_and_sampling_mode : isr_w);
			A_LCR: rd_mux = cfg_r.line_control_reg;
			A_MCR: rd_mux = enh_sel ? cfg_r.resume1 : cfg_r.modem_control_reg;
			A_LSR: rd_mux = enh_sel ? cfg_r.resume2 : lsr_w;
			A_MSR: rd_mux = enh_sel ? cfg_r.pause1 : msr_i;
			default: rd_mux = enh_sel ? cfg_r.pause2 : cfg_r.spr;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cfg_r <= '0;
			cfg_r.line_control_reg <= LCR_RST;
			cfg_r.rx_trig_sel <= TRIG_SEL_RST;
			cfg_r.tx_trig_sel <= TRIG_SEL_RST;
			ier_r <= IER_RST;
		end else begin
			if (wr_lcr) cfg_r.line_control_reg <= wd;
			if (wr_dll) cfg_r.dll <= wd;
			if (wr_dlm) cfg_r.baud_divisor_high <= wd;
			if (wr_dld) cfg_r.fraction_and_sampling_mode <= wd;
			if (wr_efr) cfg_r.enhanced_feature_control <= wd;
			if (wr_mcr) cfg_r.modem_control_reg <= mcr_nxt;
			if (wr_spr) cfg_r.spr <= wd;
			if (wr_res1) cfg_r.resume1 <= wd;
			if (wr_res2) cfg_r.resume2 <= wd;
			if (wr_pau1) cfg_r.pause1 <= wd;
			if (wr_pau2) cfg_r.pause2 <= wd;
			if (wr_fcr) cfg_r.fifo_en <= wd[FCR_FIFO_EN];
			if (fcr_take) begin
				cfg_r.rx_trig_sel <= wd[7:6];
				cfg_r.tx_trig_sel <= tx_trig_sel_nxt;
				cfg_r.dma_mode <= wd[FCR_DMA];
			end
			if (wr_ier) ier_r <= ier_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// host-side strobes and read data
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rd_data_r <= REG_RST;
			rx_pop_r <= 1'b0;
			tx_push_r <= 1'b0;
			tx_data_r <= REG_RST;
			rx_rst_r <= 1'b0;
			tx_rst_r <= 1'b0;
			msr_rd_r <= 1'b0;
		end else begin
			if (rd) rd_data_r <= rd_mux;
			rx_pop_r <= pop;
			tx_push_r <= wr_hold;
			if (wr_hold) tx_data_r <= wd;
			rx_rst_r <= fcr_take && wd[FCR_RX_RST];
			tx_rst_r <= fcr_take && wd[FCR_TX_RST];
			msr_rd_r <= rd_msr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags: set wins over clear, except the error count, which a receive fifo reset clears
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ovr_r <= 1'b0;
			errcnt_r <= 7'h00;
			tx_pend_r <= 1'b0;
			tx_cond_q_r <= 1'b0;
		end else begin
			ovr_r <= rx_i.overrun || (ovr_r && !rd_lsr);
			errcnt_r <= rx_rst_r ? 7'h00 : errcnt_nxt;
			tx_pend_r <= tx_set || (tx_pend_r && !tx_clr);
			tx_cond_q_r <= tx_cond;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			tout_cnt_r <= 8'h00;
			tout_r <= 1'b0;
		end else begin
			if (tout_restart) begin
				tout_cnt_r <= 8'h00;
			end else if (rx_i.bit_tick && (tout_cnt_r != tout_limit)) begin
				tout_cnt_r <= tout_cnt_r + 8'h01;
			end
			tout_r <= tout_set || (tout_r && !rd_hold);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt and mode outputs
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			int_r <= 1'b0;
			polled_r <= 1'b0;
		end else begin
			int_r <= any_irq;
			polled_r <= fifo_en && (ier_r[3:0] == 4'h0);
		end
	end

	assign rd_data_o = rd_data_r;
	assign cfg_o = cfg_r;
	assign ier_o = ier_r;
	assign rx_pop_o = rx_pop_r;
	assign tx_push_o = tx_push_r;
	assign tx_data_o = tx_data_r;
	assign rx_fifo_reset_o = rx_rst_r;
	assign tx_fifo_reset_o = tx_rst_r;
	assign msr_read_o = msr_rd_r;
	assign polled_mode_o = polled_r;
	assign int_o = int_r;

endmodule : uart_irq_ctrl

// ===== uart_irq_ctrl_checker.sv
// uart_irq_ctrl_checker: port assertions for the interrupt enable and line status block
// assumes one clock domain with synchronous active high reset
`timescale 1ns/1ps
module uart_irq_ctrl_checker (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire uart_irq_pkg::bus_req_t bus_i,
	input wire uart_irq_pkg::rx_stat_t rx_i,
	input wire uart_irq_pkg::tx_stat_t tx_i,
	input wire logic [7:0] rd_data_o,
	input wire uart_irq_pkg::cfg_t cfg_o,
	input wire logic [7:0] ier_o,
	input wire logic rx_pop_o,
	input wire logic tx_push_o,
	input wire logic [7:0] tx_data_o,
	input wire logic polled_mode_o,
	input wire logic rx_fifo_reset_o,
	input wire logic tx_fifo_reset_o,
	input wire logic msr_read_o,
	input wire logic int_o
);
	import uart_irq_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	wire rd_std = bus_i.rd && !cfg_o.line_control_reg[LCR_DL_EN];
	wire wr_std = bus_i.wr && !cfg_o.line_control_reg[LCR_DL_EN];

	a_mask_reset: assert property ($past(srst_i) |-> ier_o == IER_RST)
		else $error("mask not cleared by reset");
	a_thr_push: assert property (wr_std && bus_i.addr == A_HOLD |=>
		tx_push_o && tx_data_o == $past(bus_i.wdata))
		else $error("holding write not passed on");
	a_dll_write: assert property (bus_i.wr && cfg_o.line_control_reg[LCR_DL_EN]
		&& bus_i.addr == A_HOLD |=> !tx_push_o && cfg_o.dll == $past(bus_i.wdata))
		else $error("divisor low write misrouted");
	a_upper_locked: assert property (wr_std && bus_i.addr == A_MASK
		&& !cfg_o.enhanced_feature_control[EFR_ENH] |=> ier_o == {$past(ier_o[7:4]), $past(bus_i.wdata[3:0])})
		else $error("mask write wrong");
	a_mask_quiet: assert property ((ier_o[3:0] == 4'h0) [*2] |-> !int_o)
		else $error("interrupt with all sources masked");
	a_polled_mode: assert property ((cfg_o.fifo_en && ier_o[3:0] == 4'h0) [*2] |->
		polled_mode_o)
		else $error("polled mode not shown");
	a_lsr_flags: assert property (rd_std && bus_i.addr == A_LSR |=>
		rd_data_o[0] == ($past(rx_i.level) != 7'h00) &&
		rd_data_o[5] == ($past(tx_i.level) == 7'h00))
		else $error("status ready or empty flag wrong");
	a_lsr_head: assert property (rd_std && bus_i.addr == A_LSR && rx_i.level != 7'h00
		|=> rd_data_o[4:2] == $past(rx_i.head_err))
		else $error("head error bits wrong");
	a_pop_read: assert property (rd_std && bus_i.addr == A_HOLD && rx_i.level != 7'h00
		|=> rx_pop_o)
		else $error("no pop on holding read");
	a_overrun_int: assert property (ier_o[IER_LS] && rx_i.overrun |-> ##[1:3] int_o)
		else $error("overrun interrupt late");
	a_fifo_reset: assert property (wr_std && bus_i.addr == A_ISR
		&& bus_i.wdata[FCR_FIFO_EN] |=> rx_fifo_reset_o == $past(bus_i.wdata[FCR_RX_RST])
		&& tx_fifo_reset_o == $past(bus_i.wdata[FCR_TX_RST]))
		else $error("fifo reset strobe wrong");
	a_msr_strobe: assert property (rd_std && bus_i.addr == A_MSR |=> msr_read_o)
		else $error("no strobe after modem status read");
endmodule : uart_irq_ctrl_checker

bind uart_irq_ctrl uart_irq_ctrl_checker i_chk (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus_i), .rx_i(rx_i), .tx_i(tx_i),
	.rd_data_o(rd_data_o), .cfg_o(cfg_o), .ier_o(ier_o), .rx_pop_o(rx_pop_o),
	.tx_push_o(tx_push_o), .tx_data_o(tx_data_o), .polled_mode_o(polled_mode_o),
	.int_o(int_o), .rx_fifo_reset_o(rx_fifo_reset_o), .tx_fifo_reset_o(tx_fifo_reset_o),
	.msr_read_o(msr_read_o)
);

// ===== uart_irq_pkg.sv
// uart_irq_pkg: register map, field positions, reset values and carrier types for the
// interrupt enable and line-status block of one uart channel.
// assumes the channel fifos, shift registers and baud generator live outside this block.
package uart_irq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register addresses (three address lines)
	localparam logic [2:0] A_HOLD = 3'h0;
	localparam logic [2:0] A_MASK = 3'h1;
	localparam logic [2:0] A_ISR = 3'h2;
	localparam logic [2:0] A_LCR = 3'h3;
	localparam logic [2:0] A_MCR = 3'h4;
	localparam logic [2:0] A_LSR = 3'h5;
	localparam logic [2:0] A_MSR = 3'h6;
	localparam logic [2:0] A_SPR = 3'h7;
	localparam logic [2:0] A_RESUME1 = 3'h4;
	localparam logic [2:0] A_RESUME2 = 3'h5;
	localparam logic [2:0] A_PAUSE1 = 3'h6;
	localparam logic [2:0] A_PAUSE2 = 3'h7;
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int LCR_DL_EN = 7;
	localparam int LCR_PAR_EN = 3;
	localparam int LCR_STOP = 2;
	localparam int EFR_ENH = 4;
	localparam int FCR_FIFO_EN = 0;
	localparam int FCR_RX_RST = 1;
	localparam int FCR_TX_RST = 2;
	localparam int FCR_DMA = 3;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	localparam int IER_MS = 3;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] TRIG_SEL_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt source codes, highest priority first
	localparam logic [5:0] ISR_LS = 6'h06;
	localparam logic [5:0] ISR_TOUT = 6'h0C;
	localparam logic [5:0] ISR_RECEIVE_READY_EVENT = 6'h04;
	localparam logic [5:0] ISR_TRANSMIT_READY_EVENT = 6'h02;
	localparam logic [5:0] ISR_MS = 6'h00;
	localparam logic [5:0] ISR_NONE = 6'h01;

	////////////////////////////////////////////////////////////////////////////////
	// fifo depth, trigger tables and receive time-out in bit times
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [6:0] RX_TRIG_0 = 7'h08;
	localparam logic [6:0] RX_TRIG_1 = 7'h10;
	localparam logic [6:0] RX_TRIG_2 = 7'h38;
	localparam logic [6:0] RX_TRIG_3 = 7'h3C;
	localparam logic [6:0] TX_TRIG_0 = 7'h08;
	localparam logic [6:0] TX_TRIG_1 = 7'h10;
	localparam logic [6:0] TX_TRIG_2 = 7'h20;
	localparam logic [6:0] TX_TRIG_3 = 7'h38;
	localparam logic [7:0] TOUT_CHARS = 8'h04;
	localparam logic [7:0] TOUT_EXTRA_BITS = 8'h0C;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	// error bit order: [0] parity, [1] framing, [2] break
	typedef struct packed {
		logic [6:0] level;
		logic [2:0] head_err;
		logic push;
		logic [2:0] push_err;
		logic overrun;
		logic bit_tick;
	} rx_stat_t;

	typedef struct packed {
		logic [6:0] level;
		logic tsr_empty;
	} tx_stat_t;

	typedef struct packed {
		logic [7:0] line_control_reg;
		logic [7:0] dll;
		logic [7:0] baud_divisor_high;
		logic [7:0] fraction_and_sampling_mode;
		logic [7:0] enhanced_feature_control;
		logic [7:0] modem_control_reg;
		logic [7:0] spr;
		logic [7:0] resume1;
		logic [7:0] resume2;
		logic [7:0] pause1;
		logic [7:0] pause2;
		logic [1:0] rx_trig_sel;
		logic [1:0] tx_trig_sel;
		logic dma_mode;
		logic fifo_en;
	} cfg_t;

endpackage : uart_irq_pkg
